// *** spc_synth_ctrl.sv ***
// Purpose: Register file and calibration sequencer for the sampling clock synthesizer.
// Assumes: Zero wait-state APB slave; analog loop, dividers and clock gating read the outputs.
// Notes: The calibration run is timed internally; the analog loop follows cal_active.
//
// Overview of operation
// R1: Feedback divider N is a 12-bit field, values 1 to 4095.
// R2: Reference divider R is a 10-bit field, values 1 to 1023, at 0x54-0x55.
// R3: Host keeps reference times N over R within 1.075 to 1.325 GHz.
// R4: Host sets 4-bit output divider for an 80 to 250 MHz sample clock.
// R5: Host should favour lower VCO and higher comparison frequency for jitter.
// R6: Host recalibrates after reference change or divider rewrite.
// R7: Toggling the trigger bit at 0x6B runs a calibration.
// R8: Leaving soft reset at 0x00 also runs a calibration.
// R9: Read-only calibration status bit sits at 0xD1.
// R10: Low and high VCO drift bits are readable at 0xD1.
// R11: Synthesizer enable and reference divider enable sit at 0x59.
// R12: Synthesizer output enable and bias enable sit at 0x5F.
// R13: Charge-pump bias is a 4-bit field at 0x58, 25 uA steps.
// R14: Loop resistor and three capacitors are 5-bit fields at 0x5A-0x5D.
// R15: Host should use recommended charge-pump and loop-filter settings per band.
// R16: Output data clock delay in VCO cycles is a 3-bit field at 0x6D.
// R17: Synthesized clock reaches the converter only while the 0x6D enable is set.
// R18: Output divider shares 0x55 with the upper reference divider bits.
// R19: Source select 1 takes the sample clock from the synthesizer.
// R20: Calibration status reads not-done from start until the run ends.
// R21: A calibration starts on the trigger bit rising, once per toggle.
//
// Local design decisions: register access over APB and the register addresses.
module spc_synth_ctrl
   import spc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic vco_low_drift_in,
   input wire logic vco_high_drift_in,
   output logic soft_reset_active,
   output logic clk_from_synth,
   output logic [REFDIV_W-1:0] reference_divider_r,
   output logic [FBDIV_W-1:0] feedback_divider_n,
   output logic [OUTDIV_W-1:0] synth_output_divider,
   output logic [CP_W-1:0] charge_pump_current,
   output logic [LOOP_W-1:0] loop_resistor_select,
   output logic [LOOP_W-1:0] loop_cap_one_select,
   output logic [LOOP_W-1:0] loop_cap_two_select,
   output logic [LOOP_W-1:0] loop_cap_three_select,
   output logic synth_enable,
   output logic ref_divider_enable,
   output logic synth_out_enable,
   output logic synth_bias_enable,
   output logic [DLY_W-1:0] out_clock_vco_delay,
   output logic synth_clk_route_enable,
   output logic cal_active
);

   typedef struct packed {
      logic soft_reset;
      logic clk_source;
      logic [REFDIV_W-1:0] refdiv;
      logic [FBDIV_W-1:0] fbdiv;
      logic [OUTDIV_W-1:0] outdiv;
      logic [CP_W-1:0] cp;
      logic [LOOP_W-1:0] res;
      logic [LOOP_W-1:0] cap1;
      logic [LOOP_W-1:0] cap2;
      logic [LOOP_W-1:0] cap3;
      logic synth_en;
      logic refdiv_en;
      logic out_en;
      logic bias_en;
      logic cal_trigger;
      logic [DLY_W-1:0] dly;
      logic clk_route_en;
      spc_cal_state_t cal_state;
      logic [CAL_CNT_W-1:0] cal_cnt;
      logic cal_done;
      logic [DATA_W-1:0] rdata;
   } spc_ctrl_state_t;

   spc_ctrl_state_t st_q;
   spc_ctrl_state_t st_d;
   logic [DRIFT_W-1:0] drift_sync;
   logic [REG_W-1:0] wbyte;
   logic wr_en;
   logic cal_start;

   localparam spc_ctrl_state_t RESET_STATE = '{
      soft_reset: 1'b0, clk_source: 1'b0, refdiv: RST_REFDIV, fbdiv: RST_FBDIV,
      outdiv: RST_OUTDIV, cp: RST_CP, res: RST_RES, cap1: RST_CAP1, cap2: RST_CAP2,
      cap3: RST_CAP3, synth_en: 1'b0, refdiv_en: 1'b0, out_en: 1'b0, bias_en: 1'b0,
      cal_trigger: 1'b0, dly: RST_DLY, clk_route_en: 1'b0, cal_state: CAL_IDLE,
      cal_cnt: '0, cal_done: 1'b0, rdata: '0};

   // Word-aligned hit on one register index.
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
      reg_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
   endfunction

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
      addr_mapped = reg_hit(addr, IDX_SOFT_RESET) || reg_hit(addr, IDX_CLK_SOURCE) ||
                    reg_hit(addr, IDX_REFDIV_LO) || reg_hit(addr, IDX_REFDIV_OUTDIV) ||
                    reg_hit(addr, IDX_FBDIV_LO) || reg_hit(addr, IDX_FBDIV_HI) ||
                    reg_hit(addr, IDX_CHARGE_PUMP) || reg_hit(addr, IDX_SYNTH_ENABLE) ||
                    reg_hit(addr, IDX_LOOP_RES) || reg_hit(addr, IDX_LOOP_CAP3) ||
                    reg_hit(addr, IDX_LOOP_CAP1) || reg_hit(addr, IDX_LOOP_CAP2) ||
                    reg_hit(addr, IDX_OUT_BIAS_ENABLE) || reg_hit(addr, IDX_CAL_TRIGGER) ||
                    reg_hit(addr, IDX_OUT_CLOCK_CTRL) || reg_hit(addr, IDX_STATUS);
   endfunction

   // Byte value of one register.
   function automatic logic [REG_W-1:0] read_byte(input logic [ADDR_W-1:0] addr, input spc_ctrl_state_t s,
                                                  input logic [DRIFT_W-1:0] drift);
      logic [REG_W-1:0] v;
      v = '0;
      if (reg_hit(addr, IDX_SOFT_RESET))
      begin
         v[BIT_SOFT_RESET] = s.soft_reset;
      end
      if (reg_hit(addr, IDX_CLK_SOURCE))
      begin
         v[BIT_CLK_SOURCE] = s.clk_source;
      end
      if (reg_hit(addr, IDX_REFDIV_LO))
      begin
         v = s.refdiv[REG_W-1:0];
      end
      if (reg_hit(addr, IDX_REFDIV_OUTDIV))
      begin
         v[REFDIV_HI_LSB +: REFDIV_W-REG_W] = s.refdiv[REFDIV_W-1:REG_W];
         v[OUTDIV_LSB +: OUTDIV_W] = s.outdiv;
      end
      if (reg_hit(addr, IDX_FBDIV_LO))
      begin
         v = s.fbdiv[REG_W-1:0];
      end
      if (reg_hit(addr, IDX_FBDIV_HI))
      begin
         v[FBDIV_HI_W-1:0] = s.fbdiv[FBDIV_W-1:REG_W];
      end
      if (reg_hit(addr, IDX_CHARGE_PUMP))
      begin
         v[CP_W-1:0] = s.cp;
      end
      if (reg_hit(addr, IDX_SYNTH_ENABLE))
      begin
         v[BIT_SYNTH_EN] = s.synth_en;
         v[BIT_REFDIV_EN] = s.refdiv_en;
      end
      if (reg_hit(addr, IDX_LOOP_RES))
      begin
         v[LOOP_W-1:0] = s.res;
      end
      if (reg_hit(addr, IDX_LOOP_CAP3))
      begin
         v[LOOP_W-1:0] = s.cap3;
      end
      if (reg_hit(addr, IDX_LOOP_CAP1))
      begin
         v[LOOP_W-1:0] = s.cap1;
      end
      if (reg_hit(addr, IDX_LOOP_CAP2))
      begin
         v[LOOP_W-1:0] = s.cap2;
      end
      if (reg_hit(addr, IDX_OUT_BIAS_ENABLE))
      begin
         v[BIT_OUT_EN] = s.out_en;
         v[BIT_BIAS_EN] = s.bias_en;
      end
      if (reg_hit(addr, IDX_CAL_TRIGGER))
      begin
         v[BIT_CAL_TRIGGER] = s.cal_trigger;
      end
      if (reg_hit(addr, IDX_OUT_CLOCK_CTRL))
      begin
         v[DLY_LSB +: DLY_W] = s.dly;
         v[BIT_CLK_ROUTE_EN] = s.clk_route_en;
      end
      if (reg_hit(addr, IDX_STATUS))
      begin
         v[BIT_CAL_DONE] = s.cal_done; // [R9]
         v[BIT_VCO_LOW] = drift[0]; // [R10]
         v[BIT_VCO_HIGH] = drift[1]; // [R10]
      end
      read_byte = v;
   endfunction

   spc_input_sync u_drift_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({vco_high_drift_in, vco_low_drift_in}),
      .sync_out(drift_sync)
   );

   assign wbyte = pwdata[REG_W-1:0];
   // Only byte lane 0 carries data; a write without it is dropped.
   assign wr_en = psel && penable && pwrite && pstrb[0] && addr_mapped(paddr);

   // One run per trigger rise and one per soft reset release.
   assign cal_start = (wr_en && reg_hit(paddr, IDX_CAL_TRIGGER) && !st_q.cal_trigger &&
                       wbyte[BIT_CAL_TRIGGER]) || // [R7] [R21]
                      (wr_en && reg_hit(paddr, IDX_SOFT_RESET) && st_q.soft_reset &&
                       !wbyte[BIT_SOFT_RESET]); // [R8]

   always_comb
   begin
      st_d = st_q;
      // Read data is taken at setup so that prdata comes from a flop.
      if (psel && !penable)
      begin
         st_d.rdata = {{(DATA_W-REG_W){1'b0}}, read_byte(paddr, st_q, drift_sync)};
      end
      if (wr_en)
      begin
         if (reg_hit(paddr, IDX_SOFT_RESET))
         begin
            st_d.soft_reset = wbyte[BIT_SOFT_RESET];
         end
         if (reg_hit(paddr, IDX_CLK_SOURCE))
         begin
            st_d.clk_source = wbyte[BIT_CLK_SOURCE]; // [R19]
         end
         if (reg_hit(paddr, IDX_REFDIV_LO))
         begin
            st_d.refdiv[REG_W-1:0] = wbyte; // [R2]
         end
         if (reg_hit(paddr, IDX_REFDIV_OUTDIV))
         begin
            st_d.refdiv[REFDIV_W-1:REG_W] = wbyte[REFDIV_HI_LSB +: REFDIV_W-REG_W]; // [R2] [R18]
            st_d.outdiv = wbyte[OUTDIV_LSB +: OUTDIV_W]; // [R18]
         end
         if (reg_hit(paddr, IDX_FBDIV_LO))
         begin
            st_d.fbdiv[REG_W-1:0] = wbyte; // [R1]
         end
         if (reg_hit(paddr, IDX_FBDIV_HI))
         begin
            st_d.fbdiv[FBDIV_W-1:REG_W] = wbyte[FBDIV_HI_W-1:0]; // [R1]
         end
         if (reg_hit(paddr, IDX_CHARGE_PUMP))
         begin
            st_d.cp = wbyte[CP_W-1:0]; // [R13]
         end
         if (reg_hit(paddr, IDX_SYNTH_ENABLE))
         begin
            st_d.synth_en = wbyte[BIT_SYNTH_EN]; // [R11]
            st_d.refdiv_en = wbyte[BIT_REFDIV_EN]; // [R11]
         end
         if (reg_hit(paddr, IDX_LOOP_RES))
         begin
            st_d.res = wbyte[LOOP_W-1:0]; // [R14]
         end
         if (reg_hit(paddr, IDX_LOOP_CAP3))
         begin
            st_d.cap3 = wbyte[LOOP_W-1:0]; // [R14]
         end
         if (reg_hit(paddr, IDX_LOOP_CAP1))
         begin
            st_d.cap1 = wbyte[LOOP_W-1:0]; // [R14]
         end
         if (reg_hit(paddr, IDX_LOOP_CAP2))
         begin
            st_d.cap2 = wbyte[LOOP_W-1:0]; // [R14]
         end
         if (reg_hit(paddr, IDX_OUT_BIAS_ENABLE))
         begin
            st_d.out_en = wbyte[BIT_OUT_EN]; // [R12]
            st_d.bias_en = wbyte[BIT_BIAS_EN]; // [R12]
         end
         if (reg_hit(paddr, IDX_CAL_TRIGGER))
         begin
            st_d.cal_trigger = wbyte[BIT_CAL_TRIGGER]; // [R21]
         end
         if (reg_hit(paddr, IDX_OUT_CLOCK_CTRL))
         begin
            st_d.dly = wbyte[DLY_LSB +: DLY_W]; // [R16]
            st_d.clk_route_en = wbyte[BIT_CLK_ROUTE_EN]; // [R17]
         end
      end
      // A start during a run restarts the timer, so the last start always gets a full run.
      case (st_q.cal_state)
         CAL_IDLE:
         begin
            if (cal_start)
            begin
               st_d.cal_state = CAL_RUN;
               st_d.cal_cnt = '0;
               st_d.cal_done = 1'b0; // [R20]
            end
         end
         CAL_RUN:
         begin
            if (cal_start)
            begin
               st_d.cal_cnt = '0;
            end
            else if (st_q.cal_cnt == CAL_CNT_W'(CAL_CYCLES - 1))
            begin
               st_d.cal_state = CAL_IDLE;
               st_d.cal_done = 1'b1; // [R20]
            end
            else
            begin
               st_d.cal_cnt = st_q.cal_cnt + CAL_CNT_W'(1);
            end
         end
         default:
         begin
            st_d.cal_state = CAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= RESET_STATE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_mapped(paddr);
   assign soft_reset_active = st_q.soft_reset;
   assign clk_from_synth = st_q.clk_source; // [R19]
   assign reference_divider_r = st_q.refdiv;
   assign feedback_divider_n = st_q.fbdiv;
   assign synth_output_divider = st_q.outdiv;
   assign charge_pump_current = st_q.cp;
   assign loop_resistor_select = st_q.res;
   assign loop_cap_one_select = st_q.cap1;
   assign loop_cap_two_select = st_q.cap2;
   assign loop_cap_three_select = st_q.cap3;
   assign synth_enable = st_q.synth_en;
   assign ref_divider_enable = st_q.refdiv_en;
   assign synth_out_enable = st_q.out_en;
   assign synth_bias_enable = st_q.bias_en;
   assign out_clock_vco_delay = st_q.dly;
   assign synth_clk_route_enable = st_q.clk_route_en && st_q.clk_source; // [R17] [R19]
   assign cal_active = (st_q.cal_state == CAL_RUN);

endmodule

// *** spc_pkg.sv ***
// Purpose: Shared constants and types for the sampling clock synthesizer control block.
// Assumes: 32-bit APB; each register is the low byte of an aligned word at byte address 4 * index.
// Notes: Reset values of the divider and loop-filter fields give a 200 MHz sample clock from a 100 MHz reference.
package spc_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int IDX_W = 10;

   localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 10'h000;
   localparam logic [IDX_W-1:0] IDX_CLK_SOURCE = 10'h053;
   localparam logic [IDX_W-1:0] IDX_REFDIV_LO = 10'h054;
   localparam logic [IDX_W-1:0] IDX_REFDIV_OUTDIV = 10'h055;
   localparam logic [IDX_W-1:0] IDX_FBDIV_LO = 10'h056;
   localparam logic [IDX_W-1:0] IDX_FBDIV_HI = 10'h057;
   localparam logic [IDX_W-1:0] IDX_CHARGE_PUMP = 10'h058;
   localparam logic [IDX_W-1:0] IDX_SYNTH_ENABLE = 10'h059;
   localparam logic [IDX_W-1:0] IDX_LOOP_RES = 10'h05A;
   localparam logic [IDX_W-1:0] IDX_LOOP_CAP3 = 10'h05B;
   localparam logic [IDX_W-1:0] IDX_LOOP_CAP1 = 10'h05C;
   localparam logic [IDX_W-1:0] IDX_LOOP_CAP2 = 10'h05D;
   localparam logic [IDX_W-1:0] IDX_OUT_BIAS_ENABLE = 10'h05F;
   localparam logic [IDX_W-1:0] IDX_CAL_TRIGGER = 10'h06B;
   localparam logic [IDX_W-1:0] IDX_OUT_CLOCK_CTRL = 10'h06D;
   localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0D1;

   // Field widths and positions.
   localparam int REFDIV_W = 10;
   localparam int FBDIV_W = 12;
   localparam int OUTDIV_W = 4;
   localparam int CP_W = 4;
   localparam int LOOP_W = 5;
   localparam int DLY_W = 3;
   localparam int REFDIV_HI_LSB = 0;
   localparam int OUTDIV_LSB = 4;
   localparam int FBDIV_HI_W = 4;
   localparam int BIT_SOFT_RESET = 0;
   localparam int BIT_CLK_SOURCE = 0;
   localparam int BIT_SYNTH_EN = 0;
   localparam int BIT_REFDIV_EN = 1;
   localparam int BIT_OUT_EN = 0;
   localparam int BIT_BIAS_EN = 1;
   localparam int BIT_CAL_TRIGGER = 0;
   localparam int DLY_LSB = 0;
   localparam int BIT_CLK_ROUTE_EN = 3;
   localparam int BIT_CAL_DONE = 0;
   localparam int BIT_VCO_LOW = 1;
   localparam int BIT_VCO_HIGH = 2;

   // Reset values.
   localparam logic [REFDIV_W-1:0] RST_REFDIV = 10'h00A;
   localparam logic [FBDIV_W-1:0] RST_FBDIV = 12'h078;
   localparam logic [OUTDIV_W-1:0] RST_OUTDIV = 4'h6;
   localparam logic [CP_W-1:0] RST_CP = 4'h4;
   localparam logic [LOOP_W-1:0] RST_RES = 5'h1F;
   localparam logic [LOOP_W-1:0] RST_CAP3 = 5'h02;
   localparam logic [LOOP_W-1:0] RST_CAP2 = 5'h01;
   localparam logic [LOOP_W-1:0] RST_CAP1 = 5'h01;
   localparam logic [DLY_W-1:0] RST_DLY = 3'h0;

   // Calibration run time, rounded up to whole clock cycles.
   localparam int CLK_MHZ = 250;
   localparam int CAL_TIME_NS = 2000;
   localparam int CAL_CYCLES = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int CAL_CNT_W = 10;

   localparam int DRIFT_W = 2;

   typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} spc_cal_state_t;

endpackage

// *** spc_input_sync.sv ***
// Purpose: Brings the asynchronous drift indications into the pclk domain.
// Assumes: Inputs change slowly compared with pclk.
// Notes: A new level is accepted only once the second and third stages agree, filtering one-cycle glitches.
module spc_input_sync
   import spc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [DRIFT_W-1:0] async_in,
   output logic [DRIFT_W-1:0] sync_out
);

   typedef struct packed {
      logic [DRIFT_W-1:0] s1;
      logic [DRIFT_W-1:0] s2;
      logic [DRIFT_W-1:0] s3;
      logic [DRIFT_W-1:0] level;
   } spc_sync_state_t;

   spc_sync_state_t st_q;
   spc_sync_state_t st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.s1 = async_in;
      // The first stage is read only by the second stage.
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < DRIFT_W; i++)
      begin
         if (st_q.s2[i] == st_q.s3[i])
         begin
            st_d.level[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.level;

endmodule

// *** spc_synth_ctrl_monitor.sv ***
// Purpose: Port-level checker for the synthesizer control block.
// Assumes: Zero wait-state APB; register at byte address 4 * index.
// Notes: Shadows the trigger bit to tell a rising edge from a rewrite.
module spc_synth_ctrl_check
   import spc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic soft_reset_active,
   input wire logic clk_from_synth,
   input wire logic [REFDIV_W-1:0] reference_divider_r,
   input wire logic [FBDIV_W-1:0] feedback_divider_n,
   input wire logic [OUTDIV_W-1:0] synth_output_divider,
   input wire logic synth_clk_route_enable,
   input wire logic cal_active
);
   logic wr, start, trig_q;
   int cnt_q;
   logic [IDX_W-1:0] idx;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign idx = paddr[ADDR_W-1:2];
   assign wr = psel && penable && pwrite && pstrb[0] && pready && paddr[1:0] == 2'h0;
   assign start = wr && ((idx == IDX_CAL_TRIGGER && pwdata[0] && !trig_q)
                  || (idx == IDX_SOFT_RESET && !pwdata[0] && soft_reset_active));
   // A restart in mid-run is timed from its own start.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trig_q <= 1'b0;
         cnt_q <= 0;
      end
      else
      begin
         if (wr && idx == IDX_CAL_TRIGGER)
            trig_q <= pwdata[0];
         cnt_q <= start ? 0 : (cal_active ? cnt_q + 1 : cnt_q);
      end
   end
   property p_cal_start;
      start |=> cal_active;
   endproperty
   a_cal_start: assert property (p_cal_start)
      else $error("calibration did not start");
   property p_cal_once;
      wr && idx == IDX_CAL_TRIGGER && trig_q && !cal_active |=> !cal_active;
   endproperty
   a_cal_once: assert property (p_cal_once)
      else $error("calibration started without a trigger edge");
   property p_cal_len;
      $fell(cal_active) |-> cnt_q == CAL_CYCLES;
   endproperty
   a_cal_len: assert property (p_cal_len)
      else $error("calibration ended at the wrong time");
   property p_cal_bound;
      cal_active |-> cnt_q < CAL_CYCLES;
   endproperty
   a_cal_bound: assert property (p_cal_bound)
      else $error("calibration overran");
   property p_srst;
      wr && idx == IDX_SOFT_RESET |=> soft_reset_active == $past(pwdata[0]);
   endproperty
   a_srst: assert property (p_srst)
      else $error("soft reset bit not stored");
   property p_route;
      !clk_from_synth |-> !synth_clk_route_enable;
   endproperty
   a_route: assert property (p_route)
      else $error("clock routed while source is external");
   property p_fbdiv;
      wr && idx == IDX_FBDIV_HI |=> feedback_divider_n[11:8] == $past(pwdata[3:0]);
   endproperty
   a_fbdiv: assert property (p_fbdiv)
      else $error("feedback divider upper bits wrong");
   property p_refdiv;
      wr && idx == IDX_REFDIV_OUTDIV |=> reference_divider_r[9:8] == $past(pwdata[1:0])
         && synth_output_divider == $past(pwdata[7:4]);
   endproperty
   a_refdiv: assert property (p_refdiv)
      else $error("shared divider register wrong");
   property p_busy_rd;
      psel && penable && !pwrite && idx == IDX_STATUS && $past(cal_active) |-> !prdata[BIT_CAL_DONE];
   endproperty
   a_busy_rd: assert property (p_busy_rd)
      else $error("done read during calibration");
   property p_err;
      pslverr |-> psel && penable;
   endproperty
   a_err: assert property (p_err)
      else $error("error outside access phase");
endmodule

bind spc_synth_ctrl spc_synth_ctrl_check i_spc_synth_ctrl_check (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .soft_reset_active, .clk_from_synth,
   .reference_divider_r, .feedback_divider_n, .synth_output_divider, .synth_clk_route_enable, .cal_active);

// *** spc_drift_model.sv ***
// Purpose: Analog loop stand-in that raises the drift indications.
// Assumes: The bench picks the drift condition.
// Notes: Levels change away from the pclk edge, like a free-running comparator.
module spc_drift_model
(
   input wire logic pclk,
   input wire logic [1:0] want,
   output logic vco_low_drift_in,
   output logic vco_high_drift_in
);
   timeunit 1ns;
   timeprecision 100ps;
   always @(posedge pclk)
   begin
      vco_low_drift_in <= #1.3 want[0];
      vco_high_drift_in <= #1.3 want[1];
   end
endmodule

// *** spc_synth_ctrl_bench.sv ***
// Purpose: Self-checking bench for the synthesizer control block.
// Assumes: Zero wait-state APB slave; calibration lasts CAL_CYCLES.
// Notes: Outputs are sampled 1 ns after the edge; prdata and pslverr at the edge that ends the access.
module spc_synth_ctrl_bench
   import spc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic [1:0] drift_want = 2'h0;
   logic [DATA_W-1:0] prdata, rdv;
   logic pready, pslverr, soft_reset_active, clk_from_synth, synth_enable, ref_divider_enable;
   logic synth_out_enable, synth_bias_enable, synth_clk_route_enable, cal_active, erv;
   logic vco_low_drift_in, vco_high_drift_in;
   logic [REFDIV_W-1:0] reference_divider_r;
   logic [FBDIV_W-1:0] feedback_divider_n;
   logic [OUTDIV_W-1:0] synth_output_divider;
   logic [CP_W-1:0] charge_pump_current;
   logic [LOOP_W-1:0] loop_resistor_select, loop_cap_one_select, loop_cap_two_select, loop_cap_three_select;
   logic [DLY_W-1:0] out_clock_vco_delay;
   int fail_count = 0;
   int checked = 0;
   logic [IDX_W-1:0] ri [12] = '{IDX_REFDIV_LO, IDX_REFDIV_OUTDIV, IDX_FBDIV_LO, IDX_FBDIV_HI,
      IDX_CHARGE_PUMP, IDX_LOOP_RES, IDX_LOOP_CAP3, IDX_LOOP_CAP1, IDX_LOOP_CAP2, IDX_SYNTH_ENABLE,
      IDX_OUT_CLOCK_CTRL, IDX_STATUS};
   logic [7:0] rv [12] = '{RST_REFDIV[7:0], {RST_OUTDIV, 2'h0, RST_REFDIV[9:8]}, RST_FBDIV[7:0],
      8'(RST_FBDIV[11:8]), 8'(RST_CP), 8'(RST_RES), 8'(RST_CAP3), 8'(RST_CAP1), 8'(RST_CAP2), 8'h00, 8'h00, 8'h00};

   spc_synth_ctrl i_spc_synth_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .vco_low_drift_in, .vco_high_drift_in, .soft_reset_active,
      .clk_from_synth, .reference_divider_r, .feedback_divider_n, .synth_output_divider,
      .charge_pump_current, .loop_resistor_select, .loop_cap_one_select, .loop_cap_two_select,
      .loop_cap_three_select, .synth_enable, .ref_divider_enable, .synth_out_enable, .synth_bias_enable,
      .out_clock_vco_delay, .synth_clk_route_enable, .cal_active);
   spc_drift_model i_spc_drift_model (.pclk, .want(drift_want), .vco_low_drift_in, .vco_high_drift_in);

   always #2 pclk = ~pclk;

   task close_out;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer, held until pready is sampled high.
   task apb(input logic w, input logic [IDX_W-1:0] ix, input logic [7:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'h0};
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task wr(input logic [IDX_W-1:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d, 4'hF);
   endtask

   task rd(input string nm, input logic [IDX_W-1:0] ix, input logic [7:0] exp);
      apb(1'b0, ix, 8'h00, 4'hF);
      chk(nm, rdv, {24'h0, exp});
      chk(nm, erv, 0);
   endtask

   // Counts the cycles of cal_active high after the last start.
   task cal_len;
      int n;
      n = 0;
      while (cal_active === 1'b1 && n < 2000)
      begin
         n++;
         @(posedge pclk);
         #1;
      end
      chk("cal_len", n, CAL_CYCLES);
   endtask

   initial
   begin
      #40000;
      fail_count++;
      close_out();
   end

   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++)
         rd("reset_value", ri[i], rv[i]);
      wr(IDX_FBDIV_LO, 8'hFF);
      wr(IDX_FBDIV_HI, 8'h0F);
      chk("fbdiv_max", feedback_divider_n, 12'hFFF);
      wr(IDX_FBDIV_LO, 8'h01);
      wr(IDX_FBDIV_HI, 8'h00);
      chk("fbdiv_min", feedback_divider_n, 12'h001);
      wr(IDX_REFDIV_LO, 8'hFF);
      wr(IDX_REFDIV_OUTDIV, 8'hF3);
      chk("refdiv_max", reference_divider_r, 10'h3FF);
      chk("outdiv", synth_output_divider, 4'hF);
      wr(IDX_CHARGE_PUMP, 8'h0F);
      chk("cp_max", charge_pump_current, 4'hF);
      apb(1'b1, IDX_CHARGE_PUMP, 8'h02, 4'h0);
      chk("cp_nostrb", charge_pump_current, 4'hF);
      wr(IDX_LOOP_RES, 8'h07);
      wr(IDX_LOOP_CAP3, 8'h07);
      wr(IDX_LOOP_CAP2, 8'h08);
      wr(IDX_LOOP_CAP1, 8'h08);
      chk("loop", {loop_resistor_select, loop_cap_three_select, loop_cap_two_select, loop_cap_one_select},
         {5'h07, 5'h07, 5'h08, 5'h08});
      wr(IDX_SYNTH_ENABLE, 8'h03);
      chk("synth_en", {synth_enable, ref_divider_enable}, 2'b11);
      wr(IDX_SYNTH_ENABLE, 8'h02);
      chk("synth_en", {synth_enable, ref_divider_enable}, 2'b01);
      wr(IDX_OUT_BIAS_ENABLE, 8'h01);
      chk("out_en", {synth_out_enable, synth_bias_enable}, 2'b10);
      wr(IDX_OUT_BIAS_ENABLE, 8'h02);
      chk("out_en", {synth_out_enable, synth_bias_enable}, 2'b01);
      wr(IDX_OUT_CLOCK_CTRL, 8'h0F);
      chk("delay", out_clock_vco_delay, 3'h7);
      chk("route_ext", synth_clk_route_enable, 1'b0);
      wr(IDX_CLK_SOURCE, 8'h01);
      chk("route", {clk_from_synth, synth_clk_route_enable}, 2'b11);
      wr(IDX_OUT_CLOCK_CTRL, 8'h05);
      chk("route_off", {out_clock_vco_delay, synth_clk_route_enable}, 4'hA);
      apb(1'b0, 10'h3FF, 8'h00, 4'hF);
      chk("unmapped", {rdv[7:0], erv}, 9'h001);
      // 100 MHz in, 200 MHz out, then a recalibration after the rewrite.
      wr(IDX_REFDIV_LO, 8'h0A);
      wr(IDX_REFDIV_OUTDIV, 8'h60);
      wr(IDX_FBDIV_LO, 8'h78);
      wr(IDX_CAL_TRIGGER, 8'h01);
      chk("cal_run", cal_active, 1'b1);
      rd("busy", IDX_STATUS, 8'h00);
      wr(IDX_CAL_TRIGGER, 8'h00);
      wr(IDX_CAL_TRIGGER, 8'h01);
      cal_len();
      rd("done", IDX_STATUS, 8'h01);
      wr(IDX_CAL_TRIGGER, 8'h01);
      chk("retrig", cal_active, 1'b0);
      wr(IDX_STATUS, 8'h00);
      rd("status_ro", IDX_STATUS, 8'h01);
      wr(IDX_SOFT_RESET, 8'h01);
      chk("srst", {soft_reset_active, cal_active}, 2'b10);
      wr(IDX_SOFT_RESET, 8'h00);
      chk("srst_exit", {soft_reset_active, cal_active}, 2'b01);
      cal_len();
      wr(IDX_SOFT_RESET, 8'h00);
      chk("srst_again", cal_active, 1'b0);
      drift_want <= 2'b01;
      repeat (8) @(posedge pclk);
      rd("drift_low", IDX_STATUS, 8'h03);
      drift_want <= 2'b10;
      repeat (8) @(posedge pclk);
      rd("drift_high", IDX_STATUS, 8'h05);
      drift_want <= 2'b00;
      repeat (8) @(posedge pclk);
      rd("drift_clear", IDX_STATUS, 8'h01);
      close_out();
   end
endmodule
